// file: design/dft_map.vh
// register offsets, field positions, reset values and codes for the display formatter
`ifndef DFT_MAP_VH
`define DFT_MAP_VH

// register byte offsets on the bus
`define DFT_OFF_MODE        8'h00
`define DFT_OFF_POINT       8'h04
`define DFT_OFF_UNIT        8'h08
`define DFT_OFF_STATUS      8'h0C
`define DFT_OFF_OFFSET      8'h10

// reset values of the writable registers
`define DFT_MODE_RST        12'hAAA
`define DFT_POINT_RST       24'h000000
`define DFT_UNIT_RST        24'h202020

// set mode nibble codes
`define DFT_CODE_A          4'hA
`define DFT_CODE_B          4'hB
`define DFT_CODE_C          4'hC
`define DFT_CODE_D          4'hD

// decoded operating modes
`define DFT_MODE_A          2'h0
`define DFT_MODE_B          2'h1
`define DFT_MODE_C          2'h2

// label and point constants
`define DFT_SPACE_CHAR      8'h20
`define DFT_POINT_MAX       8'h05

// reading width, signed, holds +-9999999
`define DFT_RD_W            25

// status register field positions
`define DFT_ST_SET          0
`define DFT_ST_MODE         2
`define DFT_ST_INV          4
`define DFT_ST_POINT        5
`define DFT_ST_DIGITS       8
`define DFT_ST_TARE         11
`define DFT_ST_WIDE         12
`define DFT_ST_ZERO         13

`endif

// file: design/dft_sync3.v
// three-stage synchroniser for strap pins with second/third stage agreement
`timescale 1ns/1ns
module dft_sync3 #(
    parameter W = 6
) (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire [W-1:0] pin_i,
    output reg  [W-1:0] level_o
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;
    integer     k;

    // stage one feeds only stage two; a bit counts once stages two and three agree
    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_ff   <= {W{1'b0}};
            s2_ff   <= {W{1'b0}};
            s3_ff   <= {W{1'b0}};
            level_o <= {W{1'b0}};
        end else begin
            s1_ff <= pin_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (k = 0; k < W; k = k + 1) begin
                if (s2_ff[k] == s3_ff[k]) begin
                    level_o[k] <= s3_ff[k];
                end
            end
        end
    end
endmodule // dft_sync3

// file: design/dft_tare.v
// zero offset capture and subtraction for the ratiometric mode
`timescale 1ns/1ns
`include "dft_map.vh"
module dft_tare (
    input  wire                        clk_i,
    input  wire                        rst_i,
    input  wire                        tare_en_i,
    input  wire                        master_i,
    input  wire                        zero_i,
    input  wire signed [`DFT_RD_W-1:0] reading_i,
    input  wire                        valid_i,
    output reg  signed [`DFT_RD_W:0]   value_o,
    output reg                         valid_o,
    output reg                         zero_shown_o,
    output reg  signed [`DFT_RD_W-1:0] offset_o
);
    wire capture = tare_en_i & master_i & zero_i;
    wire shift   = tare_en_i & master_i & ~zero_i;

    // offset clears at reset and only moves on a capture
    always @(posedge clk_i) begin
        if (rst_i) begin
            offset_o <= {`DFT_RD_W{1'b0}};
        end else if (capture && valid_i) begin
            offset_o <= reading_i;
        end
    end

    // extra bit on the result so reading minus offset never wraps
    always @(posedge clk_i) begin
        if (rst_i) begin
            value_o      <= {(`DFT_RD_W+1){1'b0}};
            valid_o      <= 1'b0;
            zero_shown_o <= 1'b0;
        end else begin
            valid_o      <= valid_i;
            zero_shown_o <= capture;
            if (valid_i) begin
                if (capture) begin
                    value_o <= {(`DFT_RD_W+1){1'b0}};
                end else if (shift) begin
                    value_o <= {reading_i[`DFT_RD_W-1], reading_i}
                             - {offset_o[`DFT_RD_W-1], offset_o};
                end else begin
                    value_o <= {reading_i[`DFT_RD_W-1], reading_i};
                end
            end
        end
    end
endmodule // dft_tare

// file: design/dft_top.v
// display formatter: point placement, tare and digit blanking with an apb register file
`timescale 1ns/1ns
`include "dft_map.vh"
module dft_top (
    input  wire                        CLK_SYS_I,
    input  wire                        RESET_I,
    // apb slave
    input  wire                        PSEL_I,
    input  wire                        PENABLE_I,
    input  wire                        PWRITE_I,
    input  wire [7:0]                  PADDR_I,
    input  wire [31:0]                 PWDATA_I,
    output wire [31:0]                 PRDATA_O,
    output wire                        PREADY_O,
    output wire                        PSLVERR_O,
    // board straps, asynchronous
    input  wire                        POINT_SELECT_LO_I,
    input  wire                        POINT_SELECT_HI_I,
    input  wire                        BLANK_SEL_LO_I,
    input  wire                        BLANK_SEL_HI_I,
    input  wire                        SET_SEL0_I,
    input  wire                        SET_SEL1_I,
    // converted reading, same clock
    input  wire [`DFT_RD_W-1:0]        READING_I,
    input  wire                        READING_VALID_I,
    // formatted result toward the char_display_module sequencer
    output wire [`DFT_RD_W:0]          DISP_VALUE_O,
    output wire                        DISP_VALID_O,
    output wire [2:0]                  DISP_POINT_POS_O,
    output wire [2:0]                  DISP_DIGITS_O,
    output wire                        DISP_WIDE_LABEL_O,
    output wire [1:0]                  DISP_MODE_O,
    output wire                        DISP_INVERT_O,
    output wire                        DISP_ZERO_SHOWN_O
);
    // decoded mode in bits [1:0], polarity invert in bit 2
    function [2:0] decode_mode;
        input [3:0] code;
        begin
            if (code == `DFT_CODE_B) begin
                decode_mode = {1'b0, `DFT_MODE_B};
            end else if (code == `DFT_CODE_C) begin
                decode_mode = {1'b0, `DFT_MODE_C};
            end else if (code == `DFT_CODE_D) begin
                decode_mode = {1'b1, `DFT_MODE_C};
            end else begin
                decode_mode = {1'b0, `DFT_MODE_A};
            end
        end
    endfunction

    // word address hit, low two bits ignored
    function addr_hit;
        input [7:0] addr;
        input [7:0] offs;
        begin
            addr_hit = (addr[7:2] == offs[7:2]);
        end
    endfunction

    // set point code to position; codes past five show no point
    function [2:0] code_to_pos;
        input [7:0] code;
        begin
            if (code <= `DFT_POINT_MAX) begin
                code_to_pos = code[2:0];
            end else begin
                code_to_pos = 3'h0;
            end
        end
    endfunction

    // software registers
    reg  [11:0]                 mode_ff;
    reg  [23:0]                 point_ff;
    reg  [23:0]                 unit_ff;
    // bus answer registers
    reg  [31:0]                 prdata_ff;
    reg                         pready_ff;
    reg                         pslverr_ff;
    // output registers
    reg  [`DFT_RD_W:0]          disp_value_ff;
    reg                         disp_valid_ff;
    reg  [2:0]                  disp_point_ff;
    reg  [2:0]                  disp_digits_ff;
    reg                         disp_wide_ff;
    reg  [1:0]                  disp_mode_ff;
    reg                         disp_inv_ff;
    reg                         disp_zero_ff;

    wire [5:0]                  strap;
    wire                        pt_lo;
    wire                        pt_hi;
    wire                        bl_lo;
    wire                        bl_hi;
    wire [1:0]                  set_sel;
    reg  [3:0]                  mode_code;
    reg  [7:0]                  unit_first;
    reg  [2:0]                  nxt_point;
    reg  [2:0]                  nxt_digits;
    wire [2:0]                  mode_dec;
    wire                        mode_b;
    wire                        wide_label;
    wire [`DFT_RD_W:0]          tare_value;
    wire                        tare_valid;
    wire                        tare_zero;
    wire [`DFT_RD_W-1:0]        tare_offset;
    reg  [31:0]                 nxt_rdata;
    reg                         nxt_err;
    wire                        access;
    wire                        wr_done;

    // straps are board jumpers, so they are synchronised and filtered
    dft_sync3 #(
        .W       (6)
    ) u_sync (
        .clk_i   (CLK_SYS_I),
        .rst_i   (RESET_I),
        .pin_i   ({SET_SEL1_I, SET_SEL0_I, BLANK_SEL_HI_I, BLANK_SEL_LO_I,
                   POINT_SELECT_HI_I, POINT_SELECT_LO_I}),
        .level_o (strap)
    );

    assign pt_lo   = strap[0];
    assign pt_hi   = strap[1];
    assign bl_lo   = strap[2];
    assign bl_hi   = strap[3];
    assign set_sel = strap[5:4];

    // sets 0 and 1 share the first mode nibble and label
    always @* begin
        if (set_sel == 2'h3) begin
            mode_code  = mode_ff[11:8];
            unit_first = unit_ff[23:16];
        end else if (set_sel == 2'h2) begin
            mode_code  = mode_ff[7:4];
            unit_first = unit_ff[15:8];
        end else begin
            mode_code  = mode_ff[3:0];
            unit_first = unit_ff[7:0];
        end
    end

    assign mode_dec   = decode_mode(mode_code);
    assign mode_b     = (mode_dec[1:0] == `DFT_MODE_B);
    assign wide_label = (unit_first == `DFT_SPACE_CHAR);

    // in mode B the point straps act as tare master and zero capture
    dft_tare u_tare (
        .clk_i        (CLK_SYS_I),
        .rst_i        (RESET_I),
        .tare_en_i    (mode_b),
        .master_i     (pt_lo),
        .zero_i       (pt_hi),
        .reading_i    (READING_I),
        .valid_i      (READING_VALID_I),
        .value_o      (tare_value),
        .valid_o      (tare_valid),
        .zero_shown_o (tare_zero),
        .offset_o     (tare_offset)
    );

    // point position: 0 none, n = after digit n
    always @* begin
        if (set_sel != 2'h0) begin
            if (set_sel == 2'h1) begin
                nxt_point = code_to_pos(point_ff[7:0]);
            end else if (set_sel == 2'h2) begin
                nxt_point = code_to_pos(point_ff[15:8]);
            end else begin
                nxt_point = code_to_pos(point_ff[23:16]);
            end
        end else if (mode_b) begin
            nxt_point = 3'h0;
        end else begin
            nxt_point = {1'b0, pt_hi, pt_lo};
        end
    end

    // number of digits left after trailing blanking
    always @* begin
        if (bl_lo && bl_hi) begin
            nxt_digits = 3'h4;
        end else if (bl_hi) begin
            nxt_digits = 3'h5;
        end else if (bl_lo) begin
            nxt_digits = 3'h6;
        end else if (wide_label) begin
            nxt_digits = 3'h7;
        end else begin
            nxt_digits = 3'h6;
        end
    end

    // format fields follow the straps every cycle; value follows the tare stage
    always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            disp_value_ff  <= {(`DFT_RD_W+1){1'b0}};
            disp_valid_ff  <= 1'b0;
            disp_point_ff  <= 3'h0;
            disp_digits_ff <= 3'h6;
            disp_wide_ff   <= 1'b0;
            disp_mode_ff   <= `DFT_MODE_A;
            disp_inv_ff    <= 1'b0;
            disp_zero_ff   <= 1'b0;
        end else begin
            disp_valid_ff  <= tare_valid;
            if (tare_valid) begin
                disp_value_ff <= tare_value;
            end
            disp_point_ff  <= nxt_point;
            disp_digits_ff <= nxt_digits;
            disp_wide_ff   <= wide_label;
            disp_mode_ff   <= mode_dec[1:0];
            disp_inv_ff    <= mode_dec[2];
            disp_zero_ff   <= tare_zero;
        end
    end

    // apb: one wait state, answer registered in the first access cycle
    assign access  = PSEL_I & PENABLE_I;
    assign wr_done = access & pready_ff & PWRITE_I & ~pslverr_ff;

    // read mux and unmapped detection
    always @* begin
        nxt_rdata = 32'h00000000;
        nxt_err   = 1'b0;
        if (addr_hit(PADDR_I, `DFT_OFF_MODE)) begin
            nxt_rdata = {20'h00000, mode_ff};
        end else if (addr_hit(PADDR_I, `DFT_OFF_POINT)) begin
            nxt_rdata = {8'h00, point_ff};
        end else if (addr_hit(PADDR_I, `DFT_OFF_UNIT)) begin
            nxt_rdata = {8'h00, unit_ff};
        end else if (addr_hit(PADDR_I, `DFT_OFF_STATUS)) begin
            nxt_rdata[`DFT_ST_SET +: 2]    = set_sel;
            nxt_rdata[`DFT_ST_MODE +: 2]   = disp_mode_ff;
            nxt_rdata[`DFT_ST_INV]         = disp_inv_ff;
            nxt_rdata[`DFT_ST_POINT +: 3]  = disp_point_ff;
            nxt_rdata[`DFT_ST_DIGITS +: 3] = disp_digits_ff;
            nxt_rdata[`DFT_ST_TARE]        = mode_b & pt_lo;
            nxt_rdata[`DFT_ST_WIDE]        = disp_wide_ff;
            nxt_rdata[`DFT_ST_ZERO]        = disp_zero_ff;
        end else if (addr_hit(PADDR_I, `DFT_OFF_OFFSET)) begin
            nxt_rdata = {{(32-`DFT_RD_W){tare_offset[`DFT_RD_W-1]}}, tare_offset};
        end else begin
            nxt_err = 1'b1;
        end
    end

    // pready pulses for one cycle per access phase
    always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            prdata_ff  <= 32'h00000000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else if (access && !pready_ff) begin
            prdata_ff  <= PWRITE_I ? 32'h00000000 : nxt_rdata;
            pready_ff  <= 1'b1;
            pslverr_ff <= nxt_err;
        end else begin
            prdata_ff  <= 32'h00000000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    // writes land on the completing edge; status and offset are read only
    always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            mode_ff  <= `DFT_MODE_RST;
            point_ff <= `DFT_POINT_RST;
            unit_ff  <= `DFT_UNIT_RST;
        end else if (wr_done) begin
            if (addr_hit(PADDR_I, `DFT_OFF_MODE)) begin
                mode_ff <= PWDATA_I[11:0];
            end else if (addr_hit(PADDR_I, `DFT_OFF_POINT)) begin
                point_ff <= PWDATA_I[23:0];
            end else if (addr_hit(PADDR_I, `DFT_OFF_UNIT)) begin
                unit_ff <= PWDATA_I[23:0];
            end
        end
    end

    assign PRDATA_O          = prdata_ff;
    assign PREADY_O          = pready_ff;
    assign PSLVERR_O         = pslverr_ff;
    assign DISP_VALUE_O      = disp_value_ff;
    assign DISP_VALID_O      = disp_valid_ff;
    assign DISP_POINT_POS_O  = disp_point_ff;
    assign DISP_DIGITS_O     = disp_digits_ff;
    assign DISP_WIDE_LABEL_O = disp_wide_ff;
    assign DISP_MODE_O       = disp_mode_ff;
    assign DISP_INVERT_O     = disp_inv_ff;
    assign DISP_ZERO_SHOWN_O = disp_zero_ff;
endmodule // dft_top

// file: sim/dft_disp_model.sv
// behavioural stand-in for the character display module fed by the formatter
`timescale 1ns/1ns
module dft_disp_model (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire  [25:0] value_i,
    input  wire         valid_i,
    output int          frames_o,
    output logic [25:0] shown_o
);
    // a frame is latched only on the valid pulse; between frames the old one stays shown
    always @(posedge clk_i) begin
        if (rst_i) begin
            frames_o <= 0;
            shown_o  <= 26'h0;
        end else if (valid_i) begin
            frames_o <= frames_o + 1;
            shown_o  <= value_i;
        end
    end
endmodule // dft_disp_model

// file: sim/dft_top_sva.sv
// assertion checker for the display formatter top
`timescale 1ns/1ns
`include "dft_map.vh"
module dft_top_sva (
    input wire                 CLK_SYS_I,
    input wire                 RESET_I,
    input wire                 PSEL_I,
    input wire                 PENABLE_I,
    input wire                 PWRITE_I,
    input wire                 PREADY_O,
    input wire                 PSLVERR_O,
    input wire                 POINT_SELECT_LO_I,
    input wire                 POINT_SELECT_HI_I,
    input wire                 BLANK_SEL_LO_I,
    input wire                 BLANK_SEL_HI_I,
    input wire                 SET_SEL0_I,
    input wire                 SET_SEL1_I,
    input wire [`DFT_RD_W-1:0] READING_I,
    input wire                 READING_VALID_I,
    input wire [`DFT_RD_W:0]   DISP_VALUE_O,
    input wire                 DISP_VALID_O,
    input wire [2:0]           DISP_POINT_POS_O,
    input wire [2:0]           DISP_DIGITS_O,
    input wire                 DISP_WIDE_LABEL_O,
    input wire [1:0]           DISP_MODE_O,
    input wire                 DISP_INVERT_O,
    input wire                 DISP_ZERO_SHOWN_O
);
    logic [3:0] quiet_ff;
    logic [5:0] strap_ff;
    wire  [5:0] strap_now = {SET_SEL1_I, SET_SEL0_I, BLANK_SEL_HI_I, BLANK_SEL_LO_I,
                             POINT_SELECT_HI_I, POINT_SELECT_LO_I};
    wire        settled = (quiet_ff >= 4'h8);
    // straps pass a synchroniser, so the raw value, digit and set 0 point checks wait for a still spell
    always @(posedge CLK_SYS_I) begin
        strap_ff <= strap_now;
        if (RESET_I || (strap_now != strap_ff) || (PSEL_I && PWRITE_I))
            quiet_ff <= 4'h0;
        else if (quiet_ff != 4'hF)
            quiet_ff <= quiet_ff + 4'h1;
    end
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (RESET_I);
    sequence s_take;
        READING_VALID_I;
    endsequence
    sequence s_answer;
        ##2 DISP_VALID_O;
    endsequence
    property p_latency; s_take |-> s_answer; endproperty
    a_latency: assert property (p_latency) else $error("display valid late");
    property p_no_spur; DISP_VALID_O |-> $past(READING_VALID_I, 2); endproperty
    a_no_spur: assert property (p_no_spur) else $error("display valid without reading");
    property p_zero; DISP_VALID_O && DISP_ZERO_SHOWN_O |-> DISP_VALUE_O == 26'h0; endproperty
    a_zero: assert property (p_zero) else $error("capture does not show zero");
    property p_raw;
        DISP_VALID_O && settled && (DISP_MODE_O != `DFT_MODE_B || !POINT_SELECT_LO_I)
            |-> $signed(DISP_VALUE_O) == $signed($past(READING_I, 2));
    endproperty
    a_raw: assert property (p_raw) else $error("raw reading altered");
    property p_digits;
        settled |-> DISP_DIGITS_O == (BLANK_SEL_HI_I ? (BLANK_SEL_LO_I ? 3'h4 : 3'h5)
            : (BLANK_SEL_LO_I ? 3'h6 : (DISP_WIDE_LABEL_O ? 3'h7 : 3'h6)));
    endproperty
    a_digits: assert property (p_digits) else $error("digit count wrong");
    property p_point0;
        settled && !SET_SEL0_I && !SET_SEL1_I |-> DISP_POINT_POS_O ==
            ((DISP_MODE_O == `DFT_MODE_B) ? 3'h0 : {1'b0, POINT_SELECT_HI_I, POINT_SELECT_LO_I});
    endproperty
    a_point0: assert property (p_point0) else $error("set 0 point wrong");
    property p_point_max; DISP_POINT_POS_O <= 3'h5; endproperty
    a_point_max: assert property (p_point_max) else $error("point beyond fifth digit");
    property p_invert; DISP_INVERT_O |-> DISP_MODE_O == `DFT_MODE_C; endproperty
    a_invert: assert property (p_invert) else $error("invert outside mode C");
    property p_ready; $rose(PENABLE_I) && PSEL_I |-> ##1 PREADY_O; endproperty
    a_ready: assert property (p_ready) else $error("bus answer late");
    property p_err; PSLVERR_O |-> PREADY_O; endproperty
    a_err: assert property (p_err) else $error("error without ready");
endmodule // dft_top_sva

bind dft_top dft_top_sva u_sva (
    .CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .POINT_SELECT_LO_I(POINT_SELECT_LO_I), .POINT_SELECT_HI_I(POINT_SELECT_HI_I),
    .BLANK_SEL_LO_I(BLANK_SEL_LO_I), .BLANK_SEL_HI_I(BLANK_SEL_HI_I),
    .SET_SEL0_I(SET_SEL0_I), .SET_SEL1_I(SET_SEL1_I), .READING_I(READING_I),
    .READING_VALID_I(READING_VALID_I), .DISP_VALUE_O(DISP_VALUE_O),
    .DISP_VALID_O(DISP_VALID_O), .DISP_POINT_POS_O(DISP_POINT_POS_O),
    .DISP_DIGITS_O(DISP_DIGITS_O), .DISP_WIDE_LABEL_O(DISP_WIDE_LABEL_O),
    .DISP_MODE_O(DISP_MODE_O), .DISP_INVERT_O(DISP_INVERT_O),
    .DISP_ZERO_SHOWN_O(DISP_ZERO_SHOWN_O));

// file: sim/test_display_format_tare_blanking.sv
// self-checking bench for the display formatter with tare and blanking
`timescale 1ns/1ns
`include "dft_map.vh"
module test_display_format_tare_blanking;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [5:0]  strap = 6'h00;
    logic [24:0] rd_val = 25'h0;
    logic        rd_vld = 1'b0;
    wire  [31:0] prdata;
    wire         pready, pslverr, dvld, dwide, dinv, dzero;
    wire  [25:0] dval, shown;
    wire  [2:0]  dpt, ddig;
    wire  [1:0]  dmode;
    int          frames;
    int          mismatches = 0;
    int          num_checks = 0;
    int          offset_m = 0;
    int          sent = 0;
    logic [1:0]  cur_mode;
    logic [25:0] last_exp = 26'h0;

    always #5 clk = ~clk;

    dft_top dut (
        .CLK_SYS_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .POINT_SELECT_LO_I(strap[0]),
        .POINT_SELECT_HI_I(strap[1]), .BLANK_SEL_LO_I(strap[2]), .BLANK_SEL_HI_I(strap[3]),
        .SET_SEL0_I(strap[4]), .SET_SEL1_I(strap[5]), .READING_I(rd_val),
        .READING_VALID_I(rd_vld), .DISP_VALUE_O(dval), .DISP_VALID_O(dvld),
        .DISP_POINT_POS_O(dpt), .DISP_DIGITS_O(ddig), .DISP_WIDE_LABEL_O(dwide),
        .DISP_MODE_O(dmode), .DISP_INVERT_O(dinv), .DISP_ZERO_SHOWN_O(dzero));

    dft_disp_model u_disp (.clk_i(clk), .rst_i(rst), .value_i(dval), .valid_i(dvld),
                           .frames_o(frames), .shown_o(shown));

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            tally_and_finish();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk); // idle edge, so a following setup never reassigns psel in this step
    endtask

    task automatic apb_w(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk("rdata", exp, q);
        chk("slverr", {31'h0, eerr}, {31'h0, e});
    endtask

    function automatic int rnd();
        return int'($urandom_range(19999998)) - 9999999;
    endfunction

    function automatic logic [1:0] dec(input logic [3:0] c);
        case (c)
            `DFT_CODE_B: return `DFT_MODE_B;
            `DFT_CODE_C, `DFT_CODE_D: return `DFT_MODE_C;
            default: return `DFT_MODE_A;
        endcase
    endfunction

    function automatic logic [2:0] exp_pt(input logic [1:0] set, input logic [23:0] pc);
        logic [7:0] c;
        if (set == 2'd0)
            return (cur_mode == `DFT_MODE_B) ? 3'h0 : {1'b0, strap[1:0]};
        c = pc[8 * (set - 1) +: 8];
        return (c > `DFT_POINT_MAX) ? 3'h0 : c[2:0];
    endfunction

    function automatic logic [2:0] exp_dig(input logic [1:0] b, input logic wide);
        case (b)
            2'd3: return 3'h4;
            2'd2: return 3'h5;
            2'd1: return 3'h6;
            default: return wide ? 3'h7 : 3'h6;
        endcase
    endfunction

    // model of the tare path: capture on master and zero, subtract on master only
    task automatic send(input int r);
        int          n;
        logic [25:0] e;
        e = 26'(r);
        if (cur_mode == `DFT_MODE_B && strap[0]) begin
            if (strap[1])
                offset_m = r;
            e = strap[1] ? 26'h0 : 26'(r - offset_m);
        end
        rd_val <= 25'(r);
        rd_vld <= 1'b1;
        @(posedge clk);
        rd_vld <= 1'b0;
        n = 0;
        while (dvld !== 1'b1 && n < 6) begin
            @(posedge clk);
            n++;
        end
        if (n >= 6) begin
            mismatches++;
            tally_and_finish();
        end
        chk("value", {6'h0, e}, {6'h0, dval});
        sent++;
        last_exp = e;
    endtask

    initial begin
        int          r;
        logic [3:0]  nib;
        logic [7:0]  u1;
        logic [23:0] pc;
        logic        tb;
        void'($urandom(32'hDFCEF407));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rchk(`DFT_OFF_MODE, 32'h00000AAA, 1'b0);
        rchk(`DFT_OFF_UNIT, 32'h00202020, 1'b0);
        rchk(`DFT_OFF_OFFSET, 32'h0, 1'b0);
        rchk(8'h14, 32'h0, 1'b1);
        // every set with every mode code, point codes 0..5 plus set 1 codes past five from i = 8, random point and blank straps
        for (int i = 0; i < 16; i++) begin
            nib = 4'hA + 4'(i / 4);
            pc = {8'((i + 4) % 6), 8'((i + 2) % 6), 8'(i % 6 + (i / 8) * 240)};
            u1 = ($urandom & 1) ? 8'h20 : 8'h4B;
            apb_w(`DFT_OFF_MODE, {20'h0, nib, nib, nib});
            apb_w(`DFT_OFF_POINT, {8'h0, pc});
            apb_w(`DFT_OFF_UNIT, {8'h0, u1, u1, u1});
            strap <= {i[1:0], 4'($urandom)};
            cur_mode = dec(nib);
            repeat (10) @(posedge clk);
            chk("point", {29'h0, exp_pt(strap[5:4], pc)}, {29'h0, dpt});
            chk("digits", {29'h0, exp_dig(strap[3:2], u1 == 8'h20)}, {29'h0, ddig});
            chk("mode", {30'h0, cur_mode}, {30'h0, dmode});
            chk("invert", {31'h0, nib == `DFT_CODE_D}, {31'h0, dinv});
            chk("wide", {31'h0, u1 == 8'h20}, {31'h0, dwide});
            // status word assembled from the same expectations as the pins
            tb = (cur_mode == `DFT_MODE_B) && strap[0];
            rchk(`DFT_OFF_STATUS, {18'h0, tb && strap[1], u1 == 8'h20, tb,
                 exp_dig(strap[3:2], u1 == 8'h20), exp_pt(strap[5:4], pc),
                 nib == `DFT_CODE_D, cur_mode, strap[5:4]}, 1'b0);
            send(rnd());
        end
        // tare sequence in set 0: raw, capture, then subtract back to back
        apb_w(`DFT_OFF_MODE, 32'h00000BBB);
        cur_mode = `DFT_MODE_B;
        strap <= 6'h00;
        repeat (10) @(posedge clk);
        send(rnd());
        strap <= 6'h03;
        repeat (10) @(posedge clk);
        r = rnd();
        send(r);
        chk("zero_shown", 32'h1, {31'h0, dzero});
        rchk(`DFT_OFF_OFFSET, 32'(r), 1'b0);
        strap <= 6'h01;
        repeat (10) @(posedge clk);
        repeat (4) send(rnd());
        rchk(`DFT_OFF_OFFSET, 32'(offset_m), 1'b0);
        @(posedge clk);
        chk("frames", 32'(sent), 32'(frames));
        chk("shown", {6'h0, last_exp}, {6'h0, shown});
        // a mid-run reset must drop the stored offset and the formatter display value
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        offset_m = 0;
        @(posedge clk);
        rchk(`DFT_OFF_OFFSET, 32'h0, 1'b0);
        chk("value_rst", 32'h0, {6'h0, dval});
        tally_and_finish();
    end
endmodule // test_display_format_tare_blanking
